// ### rtl/ppfm_pkg.sv
// constants for the port pin function mux: mode codes, pin positions, reset values
// assumes three 8-bit ports flattened as pin = port * 8 + bit
// Summary of operation
// - While reset is held every pin of ports 0, 1 and 2 is input-only with its pull-up off.
// - Every configurable pin keeps its own output-type setting, untouched by writes to other pins.
// - A pin may be quasi-bidirectional, open drain, push-pull or input-only, which sets how it drives.
// - Port 1 bits 2 and 3 only ever drive open drain, and port 1 bit 5 never drives at all.
// - The reset-capable pin, during power-on or when the config byte enables it, resets on a low.
// - The reset-capable pin is sampled during power-on so a low there can request programming mode.
// - SPI master drives the MOSI and serial-clock pins, SPI slave takes both as inputs.
// - SPI master takes MISO as input, SPI slave drives it.
// - Each timer pin is its count input or its overflow output, timer zero's pin driving open drain.
// - All port 0 pins feed the keypad logic, which flags a match or a mismatch to a pattern.
// - Comparator outputs go to port 0 bits 0 and 6, their inputs and reference to bits 1 to 5.

package ppfm_pkg;

   localparam int PPFM_PORTS = 3;
   localparam int PPFM_BITS = 8;
   localparam int PPFM_PINS = PPFM_PORTS * PPFM_BITS;

   // output type code, first bit from mode register one, second from mode register two
   localparam logic [1:0] PPFM_MODE_QUASI = 2'h0;
   localparam logic [1:0] PPFM_MODE_PUSHPULL = 2'h1;
   localparam logic [1:0] PPFM_MODE_INPUT = 2'h2;
   localparam logic [1:0] PPFM_MODE_OPENDRAIN = 2'h3;

   // per-port reset values
   localparam logic [7:0] PPFM_MODE1_RST = 8'hFF;
   localparam logic [7:0] PPFM_MODE2_RST = 8'h00;
   localparam logic [7:0] PPFM_LATCH_RST = 8'hFF;

   // pin positions of the shared functions
   localparam int PPFM_PIN_CMP_TWO_OUT = 0;
   localparam int PPFM_PIN_CMP_TWO_IN_B = 1;
   localparam int PPFM_PIN_CMP_TWO_IN_A = 2;
   localparam int PPFM_PIN_CMP_ONE_IN_B = 3;
   localparam int PPFM_PIN_CMP_ONE_IN_A = 4;
   localparam int PPFM_PIN_CMP_REFERENCE = 5;
   localparam int PPFM_PIN_CMP_ONE_OUT = 6;
   localparam int PPFM_PIN_TIMER_ONE = 7;
   localparam int PPFM_PIN_UART_TX = 8;
   localparam int PPFM_PIN_UART_RX = 9;
   localparam int PPFM_PIN_TIMER_ZERO = 10;
   localparam int PPFM_PIN_I2C_DATA = 11;
   localparam int PPFM_PIN_EXT_INT_ONE = 12;
   localparam int PPFM_PIN_RESET = 13;
   localparam int PPFM_PIN_COMPARE_B = 14;
   localparam int PPFM_PIN_COMPARE_C = 15;
   localparam int PPFM_PIN_CAPTURE_B = 16;
   localparam int PPFM_PIN_COMPARE_D = 17;
   localparam int PPFM_PIN_SPI_MOSI = 18;
   localparam int PPFM_PIN_SPI_MISO = 19;
   localparam int PPFM_PIN_SPI_SELECT = 20;
   localparam int PPFM_PIN_SPI_CLOCK = 21;
   localparam int PPFM_PIN_COMPARE_A = 22;
   localparam int PPFM_PIN_CAPTURE_A = 23;

endpackage

// ### rtl/ppfm_pin_cell.sv
// one pad's output stage: output type, fixed-pin overrides and direction forcing
// purely combinational; the caller registers the results
`timescale 1ns/1ps
`default_nettype none

module ppfm_pin_cell (
   // configuration
   input wire logic [1:0] mode,
   input wire logic level,
   // fixed and peripheral overrides
   input wire logic force_od,
   input wire logic input_only,
   input wire logic force_in,
   input wire logic force_out,
   // pad control
   output logic drive_en,
   output logic drive_lvl,
   output logic pullup_en
);
   import ppfm_pkg::*;

   logic [1:0] promoted;
   logic [1:0] od_mode;
   logic [1:0] eff_mode;
   logic is_quasi;
   logic is_pp;
   logic is_od;

   // a role that must drive lifts an input-only pin to push-pull
   assign promoted = (mode == PPFM_MODE_INPUT && force_out) ? PPFM_MODE_PUSHPULL : mode;
   assign od_mode = (force_od && promoted != PPFM_MODE_INPUT) ? PPFM_MODE_OPENDRAIN : promoted;
   assign eff_mode = input_only ? PPFM_MODE_INPUT : od_mode;

   assign is_quasi = (eff_mode == PPFM_MODE_QUASI);
   assign is_pp = (eff_mode == PPFM_MODE_PUSHPULL);
   assign is_od = (eff_mode == PPFM_MODE_OPENDRAIN);

   // quasi and open drain only pull low; a high is left to the pull-up or the board
   assign drive_en = !force_in && (is_pp || ((is_quasi || is_od) && !level));
   assign drive_lvl = is_pp && level;
   assign pullup_en = is_quasi && (level || force_in);

endmodule // ppfm_pin_cell

`default_nettype wire

// ### rtl/ppfm_port_mux.sv
// pin configuration and alternate-function routing for ports 0, 1 and 2
// assumes pads resolve drive_en/pullup externally and all inputs are synchronous to clk
`timescale 1ns/1ps
`default_nettype none

module ppfm_port_mux (
   // clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // configuration writes, per-bit enables
   input wire logic [1:0] cfg_port,
   input wire logic cfg_wr_mode1,
   input wire logic cfg_wr_mode2,
   input wire logic cfg_wr_latch,
   input wire logic [7:0] cfg_bit_en,
   input wire logic [7:0] cfg_data,
   // reset-capable pin control
   input wire logic power_on_active,
   input wire logic reset_pin_enable,
   // comparators
   input wire logic comparator_one_output,
   input wire logic comparator_one_out_en,
   input wire logic comparator_two_output,
   input wire logic comparator_two_out_en,
   input wire logic comparator_inputs_en,
   // timers
   input wire logic timer_zero_out_en,
   input wire logic timer_zero_overflow,
   input wire logic timer_one_out_en,
   input wire logic timer_one_overflow,
   // uart and i2c
   input wire logic uart_en,
   input wire logic uart_txd,
   input wire logic i2c_en,
   input wire logic i2c_scl_out,
   input wire logic i2c_sda_out,
   // spi
   input wire logic spi_en,
   input wire logic spi_master,
   input wire logic spi_mosi_out,
   input wire logic spi_miso_out,
   input wire logic spi_sck_out,
   // capture/compare outputs, bit 0 is a
   input wire logic [3:0] compare_out_en,
   input wire logic compare_output_a,
   input wire logic compare_output_b,
   input wire logic compare_output_c,
   input wire logic compare_output_d,
   // keypad pattern match
   input wire logic [7:0] keypad_mask,
   input wire logic [7:0] keypad_pattern,
   input wire logic keypad_match_sel,
   input wire logic keypad_flag_clr,
   // pads
   input wire logic [ppfm_pkg::PPFM_PINS-1:0] pad_in,
   output logic [ppfm_pkg::PPFM_PINS-1:0] pad_out_q,
   output logic [ppfm_pkg::PPFM_PINS-1:0] pad_oe_q,
   output logic [ppfm_pkg::PPFM_PINS-1:0] pad_pullup_q,
   // toward core and peripherals
   output logic [ppfm_pkg::PPFM_PINS-1:0] pin_in_q,
   output logic [ppfm_pkg::PPFM_PINS-1:0] latch_q,
   output logic keypad_flag_q,
   output logic ext_reset_q,
   output logic isp_request_q
);
   import ppfm_pkg::*;

   // one-hot of a pin, gated by a condition
   function automatic logic [PPFM_PINS-1:0] pin_bit(input int idx, input logic v);
      pin_bit = {{(PPFM_PINS-1){1'b0}}, v} << idx;
   endfunction

   // per-bit enables placed on the chosen port
   function automatic logic [PPFM_PINS-1:0] port_mask(input logic [1:0] port,
                                                      input logic [7:0] bits);
      port_mask = {{(PPFM_PINS-8){1'b0}}, bits} << (PPFM_BITS * int'(port));
   endfunction

   logic rst_meta_q;
   logic rst_n_q;
   logic [PPFM_PINS-1:0] mode1_q;
   logic [PPFM_PINS-1:0] mode2_q;
   logic [PPFM_PINS-1:0] mode1_d;
   logic [PPFM_PINS-1:0] mode2_d;
   logic [PPFM_PINS-1:0] latch_d;
   logic [PPFM_PINS-1:0] wr_sel_mask;
   logic [PPFM_PINS-1:0] wide_data;
   logic [PPFM_PINS-1:0] alt_en;
   logic [PPFM_PINS-1:0] alt_lvl;
   logic [PPFM_PINS-1:0] force_in;
   logic [PPFM_PINS-1:0] force_out;
   logic [PPFM_PINS-1:0] force_od;
   logic [PPFM_PINS-1:0] input_only;
   logic [PPFM_PINS-1:0] level;
   logic [PPFM_PINS-1:0] cell_oe;
   logic [PPFM_PINS-1:0] cell_lvl;
   logic [PPFM_PINS-1:0] cell_pu;
   logic spi_as_master;
   logic spi_as_slave;
   logic timer_zero_lvl;
   logic rst_pin_armed;
   logic ext_reset_d;
   logic kp_match;
   logic kp_event;
   logic keypad_flag_d;
   logic isp_request_d;

   // reset release through two flops; assertion stays asynchronous
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rst_meta_q <= 1'b0;
         rst_n_q <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_n_q <= rst_meta_q;
      end
   end

   // configuration writes touch only the enabled bits of one port
   assign wr_sel_mask = port_mask(cfg_port, cfg_bit_en);
   assign wide_data = {PPFM_PORTS{cfg_data}};

   // reset pin acts only in power-on or when the config byte arms it
   assign rst_pin_armed = power_on_active || reset_pin_enable;
   assign ext_reset_d = rst_pin_armed && !pin_in_q[PPFM_PIN_RESET];

   // an external reset returns the modes and latches to their defaults
   assign mode1_d = ext_reset_d ? {PPFM_PORTS{PPFM_MODE1_RST}} :
                    cfg_wr_mode1 ? (mode1_q & ~wr_sel_mask) | (wide_data & wr_sel_mask) :
                    mode1_q;
   assign mode2_d = ext_reset_d ? {PPFM_PORTS{PPFM_MODE2_RST}} :
                    cfg_wr_mode2 ? (mode2_q & ~wr_sel_mask) | (wide_data & wr_sel_mask) :
                    mode2_q;
   assign latch_d = ext_reset_d ? {PPFM_PORTS{PPFM_LATCH_RST}} :
                    cfg_wr_latch ? (latch_q & ~wr_sel_mask) | (wide_data & wr_sel_mask) :
                    latch_q;

   always_ff @(posedge clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         mode1_q <= {PPFM_PORTS{PPFM_MODE1_RST}};
         mode2_q <= {PPFM_PORTS{PPFM_MODE2_RST}};
         latch_q <= {PPFM_PORTS{PPFM_LATCH_RST}};
      end else begin
         mode1_q <= mode1_d;
         mode2_q <= mode2_d;
         latch_q <= latch_d;
      end
   end

   // alternate function routing
   assign spi_as_master = spi_en && spi_master;
   assign spi_as_slave = spi_en && !spi_master;
   // i2c clock outranks the timer overflow when both claim the pin
   assign timer_zero_lvl = i2c_en ? i2c_scl_out : timer_zero_overflow;

   assign alt_en = pin_bit(PPFM_PIN_CMP_TWO_OUT, comparator_two_out_en)
                 | pin_bit(PPFM_PIN_CMP_ONE_OUT, comparator_one_out_en)
                 | pin_bit(PPFM_PIN_TIMER_ONE, timer_one_out_en)
                 | pin_bit(PPFM_PIN_TIMER_ZERO, i2c_en || timer_zero_out_en)
                 | pin_bit(PPFM_PIN_UART_TX, uart_en)
                 | pin_bit(PPFM_PIN_I2C_DATA, i2c_en)
                 | pin_bit(PPFM_PIN_SPI_MOSI, spi_as_master)
                 | pin_bit(PPFM_PIN_SPI_CLOCK, spi_as_master)
                 | pin_bit(PPFM_PIN_SPI_MISO, spi_as_slave)
                 | pin_bit(PPFM_PIN_COMPARE_A, compare_out_en[0])
                 | pin_bit(PPFM_PIN_COMPARE_B, compare_out_en[1])
                 | pin_bit(PPFM_PIN_COMPARE_C, compare_out_en[2])
                 | pin_bit(PPFM_PIN_COMPARE_D, compare_out_en[3]);

   assign alt_lvl = pin_bit(PPFM_PIN_CMP_TWO_OUT, comparator_two_output)
                  | pin_bit(PPFM_PIN_CMP_ONE_OUT, comparator_one_output)
                  | pin_bit(PPFM_PIN_TIMER_ONE, timer_one_overflow)
                  | pin_bit(PPFM_PIN_TIMER_ZERO, timer_zero_lvl)
                  | pin_bit(PPFM_PIN_UART_TX, uart_txd)
                  | pin_bit(PPFM_PIN_I2C_DATA, i2c_sda_out)
                  | pin_bit(PPFM_PIN_SPI_MOSI, spi_mosi_out)
                  | pin_bit(PPFM_PIN_SPI_CLOCK, spi_sck_out)
                  | pin_bit(PPFM_PIN_SPI_MISO, spi_miso_out)
                  | pin_bit(PPFM_PIN_COMPARE_A, compare_output_a)
                  | pin_bit(PPFM_PIN_COMPARE_B, compare_output_b)
                  | pin_bit(PPFM_PIN_COMPARE_C, compare_output_c)
                  | pin_bit(PPFM_PIN_COMPARE_D, compare_output_d);

   // analog inputs and receive-side roles never drive
   assign force_in = pin_bit(PPFM_PIN_CMP_TWO_IN_B, comparator_inputs_en)
                   | pin_bit(PPFM_PIN_CMP_TWO_IN_A, comparator_inputs_en)
                   | pin_bit(PPFM_PIN_CMP_ONE_IN_B, comparator_inputs_en)
                   | pin_bit(PPFM_PIN_CMP_ONE_IN_A, comparator_inputs_en)
                   | pin_bit(PPFM_PIN_CMP_REFERENCE, comparator_inputs_en)
                   | pin_bit(PPFM_PIN_UART_RX, uart_en)
                   | pin_bit(PPFM_PIN_SPI_MOSI, spi_as_slave)
                   | pin_bit(PPFM_PIN_SPI_CLOCK, spi_as_slave)
                   | pin_bit(PPFM_PIN_SPI_MISO, spi_as_master)
                   | pin_bit(PPFM_PIN_SPI_SELECT, spi_en);

   assign force_out = pin_bit(PPFM_PIN_SPI_MOSI, spi_as_master)
                    | pin_bit(PPFM_PIN_SPI_CLOCK, spi_as_master)
                    | pin_bit(PPFM_PIN_SPI_MISO, spi_as_slave);

   assign force_od = pin_bit(PPFM_PIN_TIMER_ZERO, 1'b1) | pin_bit(PPFM_PIN_I2C_DATA, 1'b1);
   assign input_only = pin_bit(PPFM_PIN_RESET, 1'b1);

   // peripheral level replaces the latch, type handling stays in the cell
   assign level = (alt_en & alt_lvl) | (~alt_en & latch_q);

   for (genvar i = 0; i < PPFM_PINS; i++) begin : g_cell
      ppfm_pin_cell u_cell (
         .mode({mode1_q[i], mode2_q[i]}),
         .level(level[i]),
         .force_od(force_od[i]),
         .input_only(input_only[i]),
         .force_in(force_in[i]),
         .force_out(force_out[i]),
         .drive_en(cell_oe[i]),
         .drive_lvl(cell_lvl[i]),
         .pullup_en(cell_pu[i])
      );
   end

   // keypad compare over all port 0 pins
   assign kp_match = ((pin_in_q[PPFM_BITS-1:0] ^ keypad_pattern) & keypad_mask) == 8'h00;
   assign kp_event = keypad_match_sel ? kp_match : !kp_match;
   // a new event in the clearing cycle keeps the flag set
   assign keypad_flag_d = kp_event || (keypad_flag_q && !keypad_flag_clr);
   // programming request sticks until the next chip reset
   assign isp_request_d = isp_request_q || (power_on_active && !pin_in_q[PPFM_PIN_RESET]);

   always_ff @(posedge clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         pad_oe_q <= '0;
         pad_out_q <= '0;
         pad_pullup_q <= '0;
         pin_in_q <= '1;
         keypad_flag_q <= 1'b0;
         ext_reset_q <= 1'b0;
         isp_request_q <= 1'b0;
      end else begin
         pad_oe_q <= cell_oe;
         pad_out_q <= cell_lvl;
         pad_pullup_q <= cell_pu;
         pin_in_q <= pad_in;
         keypad_flag_q <= keypad_flag_d;
         ext_reset_q <= ext_reset_d;
         isp_request_q <= isp_request_d;
      end
   end

   // checks

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n_q);

   logic [PPFM_PINS-1:0] in_only_mask;
   assign in_only_mask = mode1_q & ~mode2_q & ~force_out;

   sequence rst_pin_low_s;
      rst_pin_armed && !pin_in_q[PPFM_PIN_RESET];
   endsequence

   sequence spi_master_pp_s;
      spi_as_master && mode1_q[PPFM_PIN_SPI_MOSI] && !mode2_q[PPFM_PIN_SPI_MOSI];
   endsequence

   reset_default_pads_a: assert property (
      $rose(rst_n_q) |-> pad_oe_q == '0 && pad_pullup_q == '0 && mode1_q == '1)
      else $error("pads not input-only without pull-up after reset");

   cfg_isolation_a: assert property (
      (cfg_wr_mode1 || cfg_wr_mode2) && !ext_reset_d |=>
         (((mode1_q ^ $past(mode1_q)) | (mode2_q ^ $past(mode2_q))) & ~$past(wr_sel_mask)) == '0)
      else $error("config write disturbed an unselected pin");

   input_only_silent_a: assert property (
      1'b1 |=> (pad_oe_q & $past(in_only_mask)) == '0)
      else $error("input-only pin is driving");

   fixed_od_pins_a: assert property (
      !pad_out_q[PPFM_PIN_TIMER_ZERO] && !pad_out_q[PPFM_PIN_I2C_DATA]
      && !pad_pullup_q[PPFM_PIN_TIMER_ZERO] && !pad_oe_q[PPFM_PIN_RESET])
      else $error("fixed open-drain or input-only pin misbehaves");

   ext_reset_defaults_a: assert property (
      rst_pin_low_s |=> ext_reset_q && mode1_q == '1 && mode2_q == '0 ##1 pad_oe_q == '0)
      else $error("reset pin low did not restore defaults");

   isp_capture_a: assert property (
      (power_on_active && !pin_in_q[PPFM_PIN_RESET]) || isp_request_q |=> isp_request_q)
      else $error("programming request not captured or not held");

   spi_master_drive_a: assert property (
      spi_master_pp_s |=> pad_oe_q[PPFM_PIN_SPI_MOSI] && pad_out_q[PPFM_PIN_SPI_MOSI] == $past(spi_mosi_out))
      else $error("spi master does not drive mosi");

   spi_slave_inputs_a: assert property (
      spi_as_slave |=> !pad_oe_q[PPFM_PIN_SPI_MOSI] && !pad_oe_q[PPFM_PIN_SPI_CLOCK])
      else $error("spi slave drives mosi or clock");

   miso_direction_a: assert property (
      spi_as_master |=> !pad_oe_q[PPFM_PIN_SPI_MISO])
      else $error("miso driven while spi master");

   timer_zero_od_a: assert property (
      timer_zero_out_en && !i2c_en && timer_zero_overflow |=> !pad_oe_q[PPFM_PIN_TIMER_ZERO])
      else $error("timer zero pin drives a high");

   keypad_set_wins_a: assert property (
      kp_event |=> keypad_flag_q)
      else $error("keypad event lost");

   cmp_out_route_a: assert property (
      comparator_one_out_en && !mode1_q[PPFM_PIN_CMP_ONE_OUT] && mode2_q[PPFM_PIN_CMP_ONE_OUT]
      |=> pad_oe_q[PPFM_PIN_CMP_ONE_OUT]
          && pad_out_q[PPFM_PIN_CMP_ONE_OUT] == $past(comparator_one_output))
      else $error("comparator one output not on its pin");

   alt_replaces_latch_a: assert property (
      uart_en && !mode1_q[PPFM_PIN_UART_TX] && mode2_q[PPFM_PIN_UART_TX]
      |=> pad_out_q[PPFM_PIN_UART_TX] == $past(uart_txd))
      else $error("uart output did not replace the latch");

endmodule // ppfm_port_mux

`default_nettype wire

// ### bench/ppfm_board_model.sv
// board circuitry on the 24 port pads: pull-ups, external drivers, open pads
// assumes the mux pad outputs and per-pin drive requests from the bench
`timescale 1ns/1ps
`default_nettype none

module ppfm_board_model (
   // clock
   input wire logic clk,
   // mux pad side
   input wire logic [23:0] pad_out_q,
   input wire logic [23:0] pad_oe_q,
   input wire logic [23:0] pad_pullup_q,
   // external drivers
   input wire logic [23:0] ext_en,
   input wire logic [23:0] ext_lvl,
   output logic [23:0] pad_in
);
   // an open pad wanders every cycle, so nothing can lean on its last value
   logic [23:0] float_q = 24'h5a_5a5a;

   always @(posedge clk) begin
      float_q <= ~float_q;
   end

   // a low forced on the reset pin stands for a board reset or programming request
   assign pad_in = (pad_oe_q & pad_out_q) | (~pad_oe_q & ext_en & ext_lvl) |
                   (~pad_oe_q & ~ext_en & (pad_pullup_q | float_q));
endmodule // ppfm_board_model

`default_nettype wire

// ### bench/port_pin_function_mux_bench.sv
// self-checking bench for the port mux against a behavioural pin model
// assumes the board model on the pads and a 25 MHz clock
`timescale 1ns/1ps
`default_nettype none

module port_pin_function_mux_bench;
   import ppfm_pkg::*;
   logic clk = 0, reset_n = 1;
   logic [1:0] cfg_port = 0;
   logic cfg_wr_mode1 = 0, cfg_wr_mode2 = 0, cfg_wr_latch = 0;
   logic [7:0] cfg_bit_en = 0, cfg_data = 0, km = 0, kp = 0, v;
   logic power_on_active = 0, reset_pin_enable = 0, ks = 0, kc = 0;
   // peripheral side: 0 c1 out, 1 c1 en, 2 c2 out, 3 c2 en, 4 cmp inputs, 5 t0 en, 6 t0 ovf,
   // 7 t1 en, 8 t1 ovf, 9 uart en, 10 txd, 11 i2c en, 12 scl, 13 sda, 14 spi en, 15 master,
   // 16 mosi, 17 miso, 18 sck, 22:19 compare en, 26:23 compare a..d
   logic [26:0] per = 0;
   logic [23:0] ext_en = 0, ext_lvl = 0, pad_in, pad_out_q, pad_oe_q, pad_pullup_q, latch_q;
   logic [23:0] pin_in_q;
   logic keypad_flag_q, ext_reset_q, isp_request_q;
   logic m1[24], m2[24], lat[24];
   int num_errors = 0, checks = 0;

   always #20 clk = ~clk;

   ppfm_port_mux DUT (.clk, .reset_n, .cfg_port, .cfg_wr_mode1, .cfg_wr_mode2, .cfg_wr_latch,
      .cfg_bit_en, .cfg_data, .power_on_active, .reset_pin_enable,
      .comparator_one_output(per[0]), .comparator_one_out_en(per[1]),
      .comparator_two_output(per[2]), .comparator_two_out_en(per[3]),
      .comparator_inputs_en(per[4]), .timer_zero_out_en(per[5]), .timer_zero_overflow(per[6]),
      .timer_one_out_en(per[7]), .timer_one_overflow(per[8]), .uart_en(per[9]),
      .uart_txd(per[10]), .i2c_en(per[11]), .i2c_scl_out(per[12]), .i2c_sda_out(per[13]),
      .spi_en(per[14]), .spi_master(per[15]), .spi_mosi_out(per[16]), .spi_miso_out(per[17]),
      .spi_sck_out(per[18]), .compare_out_en(per[22:19]), .compare_output_a(per[23]),
      .compare_output_b(per[24]), .compare_output_c(per[25]), .compare_output_d(per[26]),
      .keypad_mask(km), .keypad_pattern(kp), .keypad_match_sel(ks), .keypad_flag_clr(kc),
      .pad_in, .pad_out_q, .pad_oe_q, .pad_pullup_q, .pin_in_q, .latch_q, .keypad_flag_q,
      .ext_reset_q, .isp_request_q);

   ppfm_board_model board (.clk, .pad_out_q, .pad_oe_q, .pad_pullup_q, .ext_en, .ext_lvl,
      .pad_in);

   // expected {oe, level, pull-up} of one pin
   function automatic logic [2:0] exp_pin(int p);
      logic [1:0] m;
      logic l, fi, fo;
      m = {m1[p], m2[p]};
      l = lat[p];
      fi = 0;
      fo = 0;
      case (p)
         0: if (per[3]) l = per[2];
         1, 2, 3, 4, 5: fi = per[4];
         6: if (per[1]) l = per[0];
         7: if (per[7]) l = per[8];
         8: if (per[9]) l = per[10];
         9: fi = per[9];
         10: l = per[11] ? per[12] : (per[5] ? per[6] : l);
         11: if (per[11]) l = per[13];
         14: if (per[20]) l = per[24];
         15: if (per[21]) l = per[25];
         17: if (per[22]) l = per[26];
         22: if (per[19]) l = per[23];
         18: begin
            fo = per[14] & per[15];
            fi = per[14] & ~per[15];
            if (fo) l = per[16];
         end
         19: begin
            fi = per[14] & per[15];
            fo = per[14] & ~per[15];
            if (fo) l = per[17];
         end
         20: fi = per[14];
         21: begin
            fo = per[14] & per[15];
            fi = per[14] & ~per[15];
            if (fo) l = per[18];
         end
         default: ;
      endcase
      if (p == 13) m = PPFM_MODE_INPUT;
      if ((p == 10 || p == 11) && m != PPFM_MODE_INPUT) m = PPFM_MODE_OPENDRAIN;
      if (fo && m == PPFM_MODE_INPUT) m = PPFM_MODE_PUSHPULL;
      if (fi) return {2'h0, m == PPFM_MODE_QUASI};
      case (m)
         PPFM_MODE_QUASI: return {~l, 1'b0, l};
         PPFM_MODE_PUSHPULL: return {1'b1, l, 1'b0};
         PPFM_MODE_OPENDRAIN: return {~l, 2'h0};
         default: return 3'h0;
      endcase
   endfunction

   task automatic mreset();
      for (int i = 0; i < 24; i++) begin
         m1[i] = PPFM_MODE1_RST[i % 8];
         m2[i] = PPFM_MODE2_RST[i % 8];
         lat[i] = PPFM_LATCH_RST[i % 8];
      end
   endtask

   task automatic tick(int n);
      repeat (n) @(posedge clk);
      #2;
   endtask

   task automatic bad(string s);
      num_errors++;
      $display("unexpected at %0t: %s", $time, s);
   endtask

   task automatic cmp_pads();
      logic [2:0] e;
      for (int i = 0; i < 24; i++) begin
         e = exp_pin(i);
         checks++;
         if (pad_oe_q[i] !== e[2] || pad_pullup_q[i] !== e[0] || (e[2] && pad_out_q[i] !== e[1]))
            bad($sformatf("pad %0d", i));
      end
   endtask

   task automatic cmp_latch();
      logic [23:0] e;
      for (int i = 0; i < 24; i++) e[i] = lat[i];
      checks++;
      if (latch_q !== e) bad("latch");
   endtask

   task automatic cmp_bit(logic got, logic exp, string what);
      checks++;
      if (got !== exp) bad(what);
   endtask

   task automatic wr(logic [2:0] w, logic [1:0] pt, logic [7:0] en, logic [7:0] d);
      cfg_port = pt;
      cfg_bit_en = en;
      cfg_data = d;
      {cfg_wr_latch, cfg_wr_mode2, cfg_wr_mode1} = w;
      for (int b = 0; b < 8; b++) begin
         if (pt < 3 && en[b]) begin
            if (w[0]) m1[pt * 8 + b] = d[b];
            if (w[1]) m2[pt * 8 + b] = d[b];
            if (w[2]) lat[pt * 8 + b] = d[b];
         end
      end
      tick(1);
      {cfg_wr_latch, cfg_wr_mode2, cfg_wr_mode1} = 3'h0;
   endtask

   task automatic end_sim();
      if (num_errors == 0 && checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   initial begin
      #200_000;
      num_errors++;
      end_sim();
   end

   initial begin
      void'($urandom(17));
      mreset();
      // a real falling edge, so the asynchronous reset acts before the first clock
      #2;
      reset_n = 0;
      tick(8);
      cmp_bit(|(pad_oe_q | pad_pullup_q), 1'b0, "reset pads");
      cmp_latch();
      reset_n = 1;
      tick(3);
      cmp_pads();
      // keypad: clear on a quiet pattern, then present a random one
      ext_en[7:0] = 8'hff;
      repeat (16) begin
         kp = 8'($urandom);
         km = 8'($urandom) | 8'h01;
         ks = 1'($urandom);
         v = 8'($urandom);
         ext_lvl[7:0] = ks ? ~kp : kp;
         tick(3);
         kc = 1;
         tick(1);
         kc = 0;
         tick(1);
         cmp_bit(keypad_flag_q, 1'b0, "keypad clear");
         ext_lvl[7:0] = v;
         tick(3);
         cmp_bit(keypad_flag_q, ((v & km) == (kp & km)) == ks, "keypad flag");
         cmp_bit(pin_in_q[7:0] === v, 1'b1, "port 0 inputs");
         // clear while the event still stands: the set must win
         kc = 1;
         tick(1);
         kc = 0;
         tick(1);
         cmp_bit(keypad_flag_q, ((v & km) == (kp & km)) == ks, "keypad set wins");
      end
      ext_en = 0;
      // random configuration and peripheral traffic
      repeat (300) begin
         per = 27'($urandom);
         wr(3'($urandom), 2'($urandom), 8'($urandom), 8'($urandom));
         tick(1);
         cmp_pads();
         cmp_latch();
      end
      // reset-capable pin
      per = 0;
      ext_en[13] = 1;
      ext_lvl[13] = 0;
      tick(4);
      cmp_bit(ext_reset_q, 1'b0, "reset pin not armed");
      reset_pin_enable = 1;
      tick(3);
      cmp_bit(ext_reset_q, 1'b1, "reset pin armed");
      mreset();
      tick(1);
      cmp_pads();
      cmp_latch();
      cmp_bit(isp_request_q, 1'b0, "programming request");
      ext_lvl[13] = 1;
      reset_pin_enable = 0;
      tick(3);
      cmp_bit(ext_reset_q, 1'b0, "reset pin release");
      power_on_active = 1;
      ext_lvl[13] = 0;
      tick(3);
      cmp_bit(ext_reset_q, 1'b1, "power-on reset pin");
      cmp_bit(isp_request_q, 1'b1, "programming request set");
      ext_lvl[13] = 1;
      power_on_active = 0;
      tick(3);
      cmp_bit(isp_request_q, 1'b1, "programming request kept");
      // second reset with quasi pins pulling up
      per = 27'($urandom);
      wr(3'h3, 2'h0, 8'hff, 8'h00);
      tick(1);
      reset_n = 0;
      #1;
      cmp_bit(|(pad_oe_q | pad_pullup_q), 1'b0, "reset in mid-run");
      cmp_bit(isp_request_q, 1'b0, "programming request reset");
      tick(2);
      reset_n = 1;
      tick(3);
      mreset();
      cmp_pads();
      cmp_latch();
      end_sim();
   end
endmodule // port_pin_function_mux_bench

`default_nettype wire
